/* host_port_handshake_tb.sv */
// Purpose: self-checking bench for both ends of the host port
// Assumes: 20 MHz clock, reset held 8 cycles
// Notes: fetch and store sides served by bench processes
`timescale 1ns/10ps
module host_port_handshake_tb import hph_pkg::*; ;
  typedef struct packed {
    logic [1:0] sel;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] addr;
  } hph_row_type;
  localparam logic [31:0] PAT = 32'ha5a5_0f0f;
  logic clk_sys, sys_rst, cmd_valid, cmd_write, fetch_ack, store_ready;
  logic [1:0] cmd_sel;
  logic [31:0] cmd_wdata, fetch_data, got_rd, last_fetch;
  logic cmd_ready, rsp_valid, fetch_req, store_valid;
  logic [31:0] rsp_rdata, fetch_addr, store_addr, store_data, port_control, port_address;
  logic [63:0] stq[$];
  int num_errors = 0;
  int compares = 0;
  int fetch_wait = 2;
  hph_row_type rows [8] = '{
    '{SEL_ADDR, 1'h1, 32'h0000_1000, 32'h0, 32'h0000_1000},
    '{SEL_CTRL, 1'h1, 32'h0000_0a5c, 32'h0, 32'h0000_1000},
    '{SEL_CTRL, 1'h0, 32'h0, 32'h0000_0a5c, 32'h0000_1000},
    '{SEL_ADDR, 1'h0, 32'h0, 32'h0000_1000, 32'h0000_1000},
    '{SEL_DATA, 1'h1, 32'h1234_5678, 32'h0, 32'h0000_1000},
    '{SEL_DATA_INC, 1'h1, 32'h9abc_def0, 32'h0, 32'h0000_1004},
    '{SEL_DATA, 1'h0, 32'h0, 32'h0000_1004 ^ PAT, 32'h0000_1004},
    '{SEL_DATA_INC, 1'h0, 32'h0, 32'h0000_1004 ^ PAT, 32'h0000_1008}};
  hph_if link();
  hph_dev i_hph_dev (.clk_sys, .sys_rst, .link(link), .fetch_req, .fetch_addr, .fetch_ack,
    .fetch_data, .store_valid, .store_ready, .store_addr, .store_data, .port_control,
    .port_address);
  hph_host i_hph_host (.clk_sys, .sys_rst, .link(link), .cmd_valid, .cmd_ready, .cmd_sel,
    .cmd_write, .cmd_wdata, .rsp_valid, .rsp_rdata);
  hph_chk i_hph_chk (.clk_sys, .sys_rst, .host_chip_select_n(link.host_chip_select_n),
    .data_strobe_a_n(link.data_strobe_a_n), .data_strobe_b_n(link.data_strobe_b_n),
    .access_selector(link.access_selector), .read_not_write(link.read_not_write),
    .halfword_select(link.halfword_select), .host_ready_n(link.host_ready_n),
    .host_data_oe_n(link.host_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n));
  // *****************
  // tasks and helpers
  // *****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_cmd(input logic [1:0] sel, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    cmd_sel = sel;
    cmd_write = wr;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    got_rd = rsp_rdata;
  endtask
  task automatic chk_store(input logic [31:0] a, input logic [31:0] d);
    logic [63:0] e;
    e = (stq.size() > 0) ? stq.pop_front() : 64'h0;
    chk("store_addr", e[63:32], a);
    chk("store_data", e[31:0], d);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    fetch_ack = 1'b0;
    fetch_data = 32'h0;
    forever begin
      @(negedge clk_sys);
      if (fetch_req === 1'b1) begin
        repeat (fetch_wait) @(negedge clk_sys);
        fetch_data = fetch_addr ^ PAT;
        last_fetch = fetch_addr;
        fetch_ack = 1'b1;
        @(negedge clk_sys);
        fetch_ack = 1'b0;
        repeat (2) @(negedge clk_sys);
      end
    end
  end
  always @(posedge clk_sys) begin
    if (store_valid === 1'b1 && store_ready === 1'b1) begin
      stq.push_back({store_addr, store_data});
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end
  // ******************
  // main test sequence
  // ******************
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_sel = 2'h0;
    cmd_write = 1'b0;
    cmd_wdata = 32'h0;
    store_ready = 1'b1;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      do_cmd(rows[i].sel, rows[i].wr, rows[i].wdata);
      if (!rows[i].wr) begin
        chk("rdata", got_rd, rows[i].rdata);
      end
      if (!rows[i].wr && rows[i].sel[0]) begin
        chk("fetch_addr", last_fetch, rows[i].rdata ^ PAT);
      end
      repeat (4) @(negedge clk_sys);
      chk("port_address", port_address, rows[i].addr);
    end
    chk("port_control", port_control, 32'h0000_0a5c);
    chk_store(32'h0000_1000, 32'h1234_5678);
    chk_store(32'h0000_1000, 32'h9abc_def0);
    fetch_wait = 30;
    do_cmd(SEL_DATA, 1'b0, 32'h0);
    chk("slow rdata", got_rd, 32'h0000_1008 ^ PAT);
    fetch_wait = 2;
    store_ready = 1'b0;
    do_cmd(SEL_DATA, 1'b1, 32'h1111_1111);
    do_cmd(SEL_DATA, 1'b1, 32'h2222_2222);
    fork begin
      do_cmd(SEL_DATA, 1'b1, 32'h3333_3333);
      do_cmd(SEL_CTRL, 1'b0, 32'h0);
    end join_none
    repeat (60) @(negedge clk_sys);
    chk("store_valid", {31'h0, store_valid}, 32'h1);
    chk("stored early", 32'(stq.size()), 32'h0);
    chk("busy at select", {31'h0, link.host_ready_n}, 32'h1);
    store_ready = 1'b1;
    wait fork;
    chk("rdata after busy", got_rd, 32'h0000_0a5c);
    repeat (4) @(negedge clk_sys);
    chk_store(32'h0000_1008, 32'h1111_1111);
    chk_store(32'h0000_1008, 32'h2222_2222);
    chk_store(32'h0000_1008, 32'h3333_3333);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("reset outs", {27'h0, link.host_ready_n, link.dev_data_oe_n, fetch_req, store_valid,
      cmd_ready}, 32'h0000_0009);
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk("ctrl reset", port_control, CTRL_RST);
    do_cmd(SEL_ADDR, 1'b0, 32'h0);
    chk("addr reset", got_rd, ADDR_RST);
    end_sim();
  end
endmodule

/* hph_buf.sv */
// Purpose: small valid/ready buffer for stored words
// Assumes: single clock
// Notes: depth is a power of two
`timescale 1ns/10ps
module hph_buf
  import hph_pkg::*;
#(
  parameter int W = 64,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("hph_buf depth must be a power of two, at least 2");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_q != DEPTH[PW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule

/* hph_chk.sv */
// Purpose: assertions on the link between host end and device end
// Assumes: one clock, synchronous active high reset
// Notes: combined strobe rebuilt here from the pins
`timescale 1ns/10ps
module hph_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_chip_select_n,
  input wire logic data_strobe_a_n,
  input wire logic data_strobe_b_n,
  input wire logic [1:0] access_selector,
  input wire logic read_not_write,
  input wire logic halfword_select,
  input wire logic host_ready_n,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n
);
  logic stb_n;
  logic last_hw_q;
  assign stb_n = ~(data_strobe_a_n ^ data_strobe_b_n) | host_chip_select_n;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_hw_q <= 1'b1;
    end else if (stb_n == 1'b0 && $past(stb_n) == 1'b1) begin
      last_hw_q <= halfword_select;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ****************
  // strobe sequences
  // ****************
  sequence s_stb_open;
    $fell(stb_n);
  endsequence
  sequence s_stb_close;
    $rose(stb_n);
  endsequence
  a_cs_gates_ready: assert property (host_chip_select_n [*3] |-> !host_ready_n)
    else $error("ready busy while select high");
  a_stb_low_min: assert property (s_stb_open |-> !stb_n [*2])
    else $error("strobe low too short");
  a_stb_high_min: assert property (s_stb_close |-> stb_n [*2])
    else $error("strobe high too short");
  a_release_after_rdy: assert property (s_stb_close |-> !$past(host_ready_n))
    else $error("strobe released before ready");
  a_sel_held: assert property (!stb_n |-> $stable({access_selector, read_not_write, halfword_select}))
    else $error("select group moved in strobe");
  a_half_order: assert property (s_stb_open |-> halfword_select != last_hw_q)
    else $error("halfwords out of order");
  a_oe_in_read: assert property ($fell(dev_data_oe_n) |-> !stb_n && read_not_write)
    else $error("device drove bus outside read");
  a_oe_release: assert property (s_stb_close |-> ##[1:4] dev_data_oe_n)
    else $error("device bus not released");
  a_no_contend: assert property (!dev_data_oe_n |-> host_data_oe_n)
    else $error("both ends drive bus");
  a_busy_data_only: assert property ($rose(host_ready_n) && !stb_n |-> access_selector[0])
    else $error("busy on non data access");
  a_rdy_after_data: assert property ($fell(host_ready_n) && !stb_n && read_not_write
      |-> !dev_data_oe_n && !$past(dev_data_oe_n))
    else $error("ready low without read data");
  a_read_busy: assert property (s_stb_open ##0 (read_not_write && access_selector[0]
      && !halfword_select) |-> ##[1:6] host_ready_n)
    else $error("no busy on data read");
endmodule

/* hph_dev.sv */
// Purpose: device end of the host access port handshake
// Assumes: host pins asynchronous, synchronised here
// Notes: stored words leave through a two-entry buffer
// Behaviour
// - strobe is xnor of data strobes, or select
// - selector, direction, halfword captured together per access
// - ready held low while select is high
// - select fall during pending work shows busy
// - data read first half requests fetch
// - busy until fetched word loaded
// - busy after data write or autoincrement read
// - other accesses keep ready low
// - control and address accesses never touch ready
// - host holds strobe until ready low
// - host strobe low at least two cycles
// - host strobe high two cycles between accesses
// - data bus driven only during read strobe
// - ready falls a cycle after read data
// - select captured on address strobe or strobe fall
// - host address strobe spans strobe falling edge
`timescale 1ns/10ps
module hph_dev
  import hph_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  hph_if.dev link,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic [31:0] fetch_data,
  output logic store_valid,
  input wire logic store_ready,
  output logic [31:0] store_addr,
  output logic [31:0] store_data,
  output logic [31:0] port_control,
  output logic [31:0] port_address
);
  // ******************************
  // pin synchroniser
  // ******************************
  logic [PIN_W-1:0] meta_q, pin_q;
  wire [PIN_W-1:0] pin_raw = {link.host_chip_select_n, link.data_strobe_a_n,
                              link.data_strobe_b_n, link.address_strobe_n,
                              link.access_selector, link.read_not_write,
                              link.halfword_select, link.host_data_bus};
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= PIN_RST;
      pin_q <= PIN_RST;
    end else begin
      meta_q <= pin_raw;
      pin_q <= meta_q;
    end
  end
  // ******************************
  // strobe and select decode
  // ******************************
  wire cs_n = pin_q[23];
  wire stb_n = hph_strobe_n(pin_q[23], pin_q[22], pin_q[21]);
  wire as_n = pin_q[20];
  wire [3:0] sel_in = pin_q[19:16];
  wire [15:0] wdata = pin_q[15:0];
  logic stb_q, as_q;
  logic [3:0] sel_q;
  wire stb_fall = stb_q & ~stb_n;
  wire stb_rise = ~stb_q & stb_n;
  wire as_fall = as_q & ~as_n;
  wire cap_now = as_fall | (stb_fall & as_n);
  wire [3:0] cap_sel = cap_now ? sel_in : sel_q;
  wire [1:0] acc = cap_sel[3:2];
  wire rnw = cap_sel[1];
  wire hw = cap_sel[0];
  wire is_data = hph_is_data(acc);
  wire autoinc = (acc == SEL_DATA_INC);
  // ******************************
  // state
  // ******************************
  logic [31:0] ctrl_q, addr_q, tdr_q;
  logic [15:0] wlow_q, dout_q;
  logic oe_n_q, busy_q, fetch_q, push_q, inc_q;
  logic [1:0] show_q;
  logic [3:0] cnt_q;
  logic buf_in_ready;
  wire [31:0] rd_word = (acc == SEL_CTRL) ? ctrl_q : ((acc == SEL_ADDR) ? addr_q : tdr_q);
  wire [15:0] rd_half = hw ? rd_word[31:16] : rd_word[15:0];
  wire [31:0] wr_word = {wdata, wlow_q};
  wire rd_first = stb_fall & rnw & is_data & ~hw;
  wire rd_other = stb_fall & rnw & ~rd_first;
  wire wr_low = stb_rise & ~rnw & ~hw;
  wire wr_high = stb_rise & ~rnw & hw;
  wire wr_data = wr_high & is_data;
  wire inc_rd_end = stb_rise & rnw & hw & autoinc;
  wire fetch_done = fetch_q & fetch_ack;
  wire push_done = push_q & buf_in_ready;
  wire cnt_done = (cnt_q == 4'h1);
  // ******************************
  // select capture and edges
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stb_q <= 1'b1;
      as_q <= 1'b1;
      sel_q <= 4'h0;
    end else begin
      stb_q <= stb_n;
      as_q <= as_n;
      if (cap_now) begin
        sel_q <= sel_in;
      end
    end
  end
  // ******************************
  // read path and bus drive
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oe_n_q <= 1'b1;
      dout_q <= 16'h0000;
      show_q <= 2'h0;
    end else begin
      oe_n_q <= ~(~stb_n & rnw);
      show_q <= {show_q[0], fetch_done};
      if (show_q[0]) begin
        dout_q <= tdr_q[15:0];
      end else if (rd_other) begin
        dout_q <= rd_half;
      end
    end
  end
  // ******************************
  // registers and busy tracking
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      addr_q <= ADDR_RST;
      tdr_q <= DATA_RST;
      wlow_q <= 16'h0000;
      busy_q <= 1'b0;
      fetch_q <= 1'b0;
      push_q <= 1'b0;
      inc_q <= 1'b0;
      cnt_q <= CNT_RST;
    end else begin
      if (wr_low) begin
        wlow_q <= wdata;
      end
      if (wr_high && acc == SEL_CTRL) begin
        ctrl_q <= wr_word;
      end
      if (wr_high && acc == SEL_ADDR) begin
        addr_q <= wr_word;
      end
      if (fetch_done) begin
        tdr_q <= fetch_data;
        fetch_q <= 1'b0;
      end
      if (show_q[1]) begin
        busy_q <= 1'b0;
      end
      if (push_done) begin
        push_q <= 1'b0;
        busy_q <= 1'b0;
        if (inc_q) begin
          addr_q <= addr_q + ADDR_STEP;
        end
      end
      if (cnt_q != CNT_RST) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_done) begin
          addr_q <= addr_q + ADDR_STEP;
          busy_q <= 1'b0;
        end
      end
      // sets after clears, so new work wins over an old completion
      if (rd_first) begin
        fetch_q <= 1'b1;
        busy_q <= 1'b1;
      end
      if (wr_data) begin
        tdr_q <= wr_word;
        push_q <= 1'b1;
        inc_q <= autoinc;
        busy_q <= 1'b1;
      end
      if (inc_rd_end) begin
        cnt_q <= DONE_CYC[3:0];
        busy_q <= 1'b1;
      end
    end
  end
  // ******************************
  // store buffer
  // ******************************
  hph_buf #(
    .W(64),
    .DEPTH(2)
  ) u_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(push_q),
    .in_ready(buf_in_ready),
    .in_data({addr_q, tdr_q}),
    .out_valid(store_valid),
    .out_ready(store_ready),
    .out_data({store_addr, store_data})
  );
  // ******************************
  // outputs
  // ******************************
  // busy shows only while selected; other accesses leave it low
  assign link.host_ready_n = cs_n ? 1'b0 : busy_q;
  assign link.dev_data_out = dout_q;
  assign link.dev_data_oe_n = oe_n_q;
  assign fetch_req = fetch_q;
  assign fetch_addr = addr_q;
  assign port_control = ctrl_q;
  assign port_address = addr_q;
endmodule

/* hph_host.sv */
// Purpose: host end driving the asynchronous host access port
// Assumes: device ready and data synchronised here
// Notes: one command moves one word as two halfwords
`timescale 1ns/10ps
module hph_host
  import hph_pkg::*;
#(
  parameter bit USE_AS = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  hph_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_sel,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata
);
  if (RDY_SETTLE_CYC < STB_LOW_CYC || RDY_SETTLE_CYC > 15) begin : g_chk
    $error("hph_host settle count out of range");
  end
  hph_hst_type st_q;
  logic [16:0] meta_q, in_q;
  logic [3:0] cnt_q;
  logic half_q, wr_q, as_n_q, rsp_q;
  logic [1:0] sel_q;
  logic [31:0] wd_q, rd_q;
  wire rdy_n = in_q[16];
  wire cnt_zero = (cnt_q == CNT_RST);
  wire in_word = (st_q != H_IDLE) & (st_q != H_DONE);
  // ******************************
  // input synchroniser
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= 17'h00000;
      in_q <= 17'h00000;
    end else begin
      meta_q <= {link.host_ready_n, link.host_data_bus};
      in_q <= meta_q;
    end
  end
  // ******************************
  // access sequencer
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= H_IDLE;
      cnt_q <= CNT_RST;
      half_q <= 1'b0;
      wr_q <= 1'b0;
      sel_q <= SEL_CTRL;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      as_n_q <= 1'b1;
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      if (!cnt_zero) begin
        cnt_q <= cnt_q - 4'h1;
      end
      case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            sel_q <= cmd_sel;
            wr_q <= cmd_write;
            wd_q <= cmd_wdata;
            half_q <= 1'b0;
            cnt_q <= SETUP_CYC[3:0];
            st_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (cnt_q == 4'h1) begin
            as_n_q <= ~USE_AS;
          end
          if (cnt_zero) begin
            cnt_q <= RDY_SETTLE_CYC[3:0];
            st_q <= H_STB;
          end
        end
        H_STB: begin
          // strobe released only once ready is seen low
          if (cnt_zero && !rdy_n) begin
            if (half_q) begin
              rd_q[31:16] <= in_q[15:0];
            end else begin
              rd_q[15:0] <= in_q[15:0];
            end
            as_n_q <= 1'b1;
            cnt_q <= STB_HIGH_CYC[3:0];
            st_q <= H_GAP;
          end
        end
        H_GAP: begin
          if (cnt_zero) begin
            if (half_q) begin
              st_q <= H_DONE;
            end else begin
              half_q <= 1'b1;
              cnt_q <= SETUP_CYC[3:0];
              st_q <= H_SETUP;
            end
          end
        end
        H_DONE: begin
          rsp_q <= 1'b1;
          st_q <= H_IDLE;
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end
  // ******************************
  // pins and user outputs
  // ******************************
  assign link.host_chip_select_n = ~in_word;
  assign link.data_strobe_a_n = (st_q != H_STB);
  assign link.data_strobe_b_n = 1'b1;
  assign link.address_strobe_n = as_n_q;
  assign link.access_selector = sel_q;
  assign link.read_not_write = ~wr_q;
  assign link.halfword_select = half_q;
  assign link.host_data_out = half_q ? wd_q[31:16] : wd_q[15:0];
  assign link.host_data_oe_n = ~(in_word & wr_q);
  assign cmd_ready = (st_q == H_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rd_q;
endmodule

/* hph_if.sv */
// Purpose: pins between external host and host access port
// Assumes: both ends on clk_sys
// Notes: output enables are active low
`timescale 1ns/10ps
interface hph_if;
  logic host_chip_select_n;
  logic data_strobe_a_n;
  logic data_strobe_b_n;
  logic address_strobe_n;
  logic [1:0] access_selector;
  logic read_not_write;
  logic halfword_select;
  logic host_ready_n;
  logic [15:0] host_data_out;
  logic host_data_oe_n;
  logic [15:0] dev_data_out;
  logic dev_data_oe_n;
  logic [15:0] host_data_bus;
  // ******************************
  // bus level from the two enables
  // ******************************
  assign host_data_bus = !dev_data_oe_n ? dev_data_out :
                         (!host_data_oe_n ? host_data_out : 16'h0000);
  modport dev (
    input host_chip_select_n, data_strobe_a_n, data_strobe_b_n, address_strobe_n,
    input access_selector, read_not_write, halfword_select, host_data_bus,
    output host_ready_n, dev_data_out, dev_data_oe_n
  );
  modport host (
    output host_chip_select_n, data_strobe_a_n, data_strobe_b_n, address_strobe_n,
    output access_selector, read_not_write, halfword_select,
    output host_data_out, host_data_oe_n,
    input host_ready_n, host_data_bus
  );
endinterface

/* hph_pkg.sv */
// Purpose: shared constants and types of the host port handshake
// Assumes: one 20 MHz clock on both ends
// Notes: access selector codes pick the register behind the port
package hph_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STB_LOW_MIN_NS = 100;
  localparam int STB_HIGH_MIN_NS = 100;
  localparam int STB_LOW_CYC = (STB_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STB_HIGH_CYC = (STB_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RDY_SETTLE_CYC = 8;
  localparam int SETUP_CYC = 2;
  localparam int DONE_CYC = 2;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int PIN_W = 24;
  localparam logic [23:0] PIN_RST = 24'hf00000;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [31:0] ADDR_RST = 32'h0;
  localparam logic [31:0] DATA_RST = 32'h0;
  localparam logic [31:0] ADDR_STEP = 32'h4;
  localparam logic [3:0] CNT_RST = 4'h0;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_STB = 3'b011,
    H_GAP = 3'b010,
    H_DONE = 3'b110
  } hph_hst_type;
  // combined strobe, low while strobes differ and select is low
  function automatic logic hph_strobe_n(input logic cs_n, input logic a_n, input logic b_n);
    return ~(a_n ^ b_n) | cs_n;
  endfunction
  function automatic logic hph_is_data(input logic [1:0] acc);
    return acc[0];
  endfunction
endpackage
